// ### dv/core_reset_move_properties.sv
`timescale 1ns/1ns
module core_reset_move_check (
  // clock, reset and causes
  input wire logic        SYS_CLK_I,
  input wire logic        RESET_I,
  input wire logic        POR_I,
  input wire logic        MASTER_CLEAR_PIN_I,
  input wire logic        WDT_I,
  input wire logic        PIN_WAKE_I,
  // instruction and register port
  input wire logic [11:0] INSTR_I,
  input wire logic        INSTR_VALID_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [4:0]  ADDR_I,
  // outputs
  input wire logic [11:0] PASS_INSTR_O,
  input wire logic        PASS_VALID_O,
  input wire logic [7:0]  RDATA_O,
  input wire logic [7:0]  DIR_O,
  input wire logic [7:0]  PORT_O
);
  // ----
  // reset-cause sequences
  // ----
  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RESET_I);
  logic cause;
  logic exec;
  assign cause = POR_I | MASTER_CLEAR_PIN_I | WDT_I | PIN_WAKE_I;
  // a cause pulse overrides the word, so only clean cycles count
  assign exec = INSTR_VALID_I && !cause;
  sequence st_rd_s;
    RD_I && !cause && ADDR_I == core_pkg::ADDR_STATUS;
  endsequence
  sequence pc_rd_s;
    RD_I && !cause && ADDR_I == core_pkg::ADDR_PCL;
  endsequence
  sequence late_s;
    (MASTER_CLEAR_PIN_I || WDT_I) && !PIN_WAKE_I && !POR_I;
  endsequence
  // ----
  // properties
  // ----
  dir_forced_a: assert property (cause |=> ##1 DIR_O == 8'hff)
    else $error("direction not forced");
  pc_reload_a: assert property (cause ##[1:4] pc_rd_s |=> RDATA_O == 8'hff)
    else $error("pc low not reloaded");
  wake_code_a: assert property (PIN_WAKE_I && !POR_I ##[1:2] st_rd_s
    |=> RDATA_O[7:3] == 5'h12)
    else $error("wake status code wrong");
  bit7_clear_a: assert property (late_s ##[1:2] st_rd_s |=> !RDATA_O[7])
    else $error("status bit 7 left set");
  wdt_code_a: assert property (WDT_I && !PIN_WAKE_I && !POR_I ##[1:2] st_rd_s
    |=> RDATA_O[7:4] == 4'h0)
    else $error("watchdog status code wrong");
  gap_zero_a: assert property (RD_I && ADDR_I inside {[5'h07:5'h17]}
    |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  idle_quiet_a: assert property (exec && !WR_I && INSTR_I == 12'h000
    |=> !PASS_VALID_O && $stable(PORT_O))
    else $error("idle word had an effect");
  literal_kept_a: assert property (exec && INSTR_I[11:8] == 4'hc
    |=> !PASS_VALID_O)
    else $error("literal load passed on");
  pass_word_a: assert property (exec && INSTR_I[11:8] == 4'hf
    |=> PASS_VALID_O && PASS_INSTR_O == $past(INSTR_I))
    else $error("foreign word not passed");
endmodule : core_reset_move_check

bind core_reset_move core_reset_move_check i_core_reset_move_check (
  .SYS_CLK_I, .RESET_I, .POR_I, .MASTER_CLEAR_PIN_I, .WDT_I, .PIN_WAKE_I, .INSTR_I,
  .INSTR_VALID_I, .WR_I, .RD_I, .ADDR_I, .PASS_INSTR_O, .PASS_VALID_O,
  .RDATA_O, .DIR_O, .PORT_O);

// ### dv/core_reset_move_tb.sv
`timescale 1ns/1ns
module core_reset_move_tb;
  // ----
  // stimulus and model state
  // ----
  localparam logic [4:0] a_st  = core_pkg::ADDR_STATUS;
  localparam logic [4:0] a_pcl = core_pkg::ADDR_PCL;
  localparam logic [4:0] a_w   = core_pkg::ADDR_WORKING;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        por = 1'b0, master_clear_pin = 1'b0, wdt = 1'b0, wake = 1'b0;
  logic        sleep = 1'b0, big = 1'b0, ivalid = 1'b0;
  logic        wr = 1'b0, rd = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [4:0]  addr = 5'h00;
  logic [7:0]  wdata = 8'h00;
  wire  [11:0] pass_instr;
  wire         pass_valid, irq;
  wire  [7:0]  rdata, dir, port;
  logic [15:0] rnd = 16'd12474;
  logic [7:0]  st, pv;
  int          n_mismatch = 0;
  int          tests_run = 0;

  core_reset_move i_core_reset_move (
    .SYS_CLK_I(clk), .RESET_I(rst), .POR_I(por), .MASTER_CLEAR_PIN_I(master_clear_pin),
    .WDT_I(wdt), .PIN_WAKE_I(wake), .SLEEP_I(sleep), .BIG_MEM_I(big),
    .INSTR_I(instr), .INSTR_VALID_I(ivalid), .PASS_INSTR_O(pass_instr),
    .PASS_VALID_O(pass_valid), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .DIR_O(dir), .PORT_O(port), .IRQ_O(irq));

  // ----
  // helpers
  // ----
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // mask hides bits left undefined by power-on
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e,
                        input logic [7:0] m = 8'hff);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask : rd_chk
  task automatic op(input logic [11:0] w);
    @(posedge clk);
    instr  <= w;
    ivalid <= 1'b1;
    @(posedge clk);
    ivalid <= 1'b0;
    #1;
  endtask : op
  task automatic pulse(input int k);
    @(posedge clk);
    master_clear_pin  <= k < 2;
    wdt   <= k == 2 || k == 3;
    wake  <= k == 4;
    por   <= k == 5;
    sleep <= k == 1 || k == 3;
    @(posedge clk);
    {master_clear_pin, wdt, wake, por} <= 4'h0;
    #1;
  endtask : pulse

  // ----
  // sequence
  // ----
  initial forever #4 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    st = 8'h18;
    rd_chk(a_st, st);
    rd_chk(core_pkg::ADDR_POINTER, 8'he0);
    rd_chk(a_pcl, 8'hff);
    chk(dir, 8'hff);
    wr_reg(5'h10, 8'hff);
    rd_chk(5'h10, 8'h00);
    // first pass uses zero so the zero flag sets, later ones clear it
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      pv = (i == 0) ? 8'h00 : {2'b00, rnd[5:0]};
      op({4'hc, pv});
      rd_chk(a_w, pv);
      op(12'h026);
      // port pins follow the port register one cycle later
      #8 chk(port, pv);
      op(12'hcff);
      op(12'h206);
      st[2] = pv == 8'h00;
      rd_chk(a_w, pv);
      rd_chk(a_st, st);
      op(12'h226);
      op(12'h000);
      chk(pass_valid, 1'b0);
      chk(port, pv);
      op({4'hf, pv});
      chk(pass_valid, 1'b1);
      chk(pass_instr, {4'hf, pv});
    end
    wr_reg(core_pkg::ADDR_IRQ_CLR, 8'hff);
    wr_reg(core_pkg::ADDR_IRQ_EN, 8'h01);
    for (int k = 0; k < 5; k++) begin
      wr_reg(a_st, 8'hff);
      wr_reg(core_pkg::ADDR_DIR, 8'h00);
      st = (st & 8'h98) | 8'h67;
      pulse(k);
      case (k)
        0: st = st & 8'h1f;
        1: st = (st & 8'h07) | 8'h10;
        2: st = st & 8'h0f;
        3: st = st & 8'h07;
        default: st = (st & 8'h07) | 8'h90;
      endcase
      rd_chk(a_st, st);
      rd_chk(a_pcl, 8'hff);
      chk(dir, 8'hff);
      chk(port, pv);
      chk(irq, 1'b1);
      // last pass masks instead of clearing
      wr_reg(k == 4 ? core_pkg::ADDR_IRQ_EN : core_pkg::ADDR_IRQ_CLR,
             k == 4 ? 8'h00 : 8'h01);
      repeat (2) @(posedge clk);
      #1 chk(irq, 1'b0);
    end
    big <= 1'b1;
    pulse(5);
    rd_chk(core_pkg::ADDR_POINTER, 8'hc0);
    rd_chk(a_st, 8'h18, 8'hf8);
    test_done();
  end
endmodule : core_reset_move_tb

// ### include/core_pkg.sv
package core_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_INDIRECT = 5'h00;
  localparam logic [4:0] ADDR_TIMER    = 5'h01;
  localparam logic [4:0] ADDR_PCL      = 5'h02;
  localparam logic [4:0] ADDR_STATUS   = 5'h03;
  localparam logic [4:0] ADDR_POINTER  = 5'h04;
  localparam logic [4:0] ADDR_TRIM     = 5'h05;
  localparam logic [4:0] ADDR_PORT     = 5'h06;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h18;
  localparam logic [4:0] ADDR_IRQ_EN   = 5'h19;
  localparam logic [4:0] ADDR_IRQ_CLR  = 5'h1a;
  localparam logic [4:0] ADDR_OPTION   = 5'h1b;
  localparam logic [4:0] ADDR_DIR      = 5'h1c;
  localparam logic [4:0] ADDR_WORKING  = 5'h1d;
  localparam logic [4:0] ADDR_INSTR    = 5'h1e;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PCL_RESET      = 8'hff;
  localparam logic [7:0] DIR_RESET      = 8'hff;
  localparam logic [7:0] STATUS_POR     = 8'h18;
  localparam logic [7:0] POINTER_POR    = 8'he0;
  localparam logic [7:0] POINTER_POR_BIG = 8'hc0;
  localparam logic [7:0] POINTER_HI_MASK = 8'he0;
  localparam logic [7:0] POINTER_HI_BIG  = 8'hc0;
  localparam logic [7:0] OPTION_TOP     = 8'hc0;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;

  // status bit positions
  localparam int ST_WAKE = 7;
  localparam int ST_TO   = 4;
  localparam int ST_PD   = 3;
  localparam int ST_Z    = 2;

  // ----------------------------------------------------------------
  // instruction patterns
  // ----------------------------------------------------------------
  localparam logic [11:0] MOVE_REG_MASK = 12'hfc0;
  localparam logic [11:0] MOVE_REG_PAT  = 12'h200;
  localparam logic [11:0] LOAD_LIT_MASK = 12'hf00;
  localparam logic [11:0] LOAD_LIT_PAT  = 12'hc00;
  localparam logic [11:0] STORE_W_MASK  = 12'hfe0;
  localparam logic [11:0] STORE_W_PAT   = 12'h020;
  localparam logic [11:0] IDLE_PAT      = 12'h000;

  // reset causes
  typedef enum logic [2:0] {
    CAUSE_MASTER_CLEAR_PIN_RUN  = 3'h0,
    CAUSE_MASTER_CLEAR_PIN_SLP  = 3'h1,
    CAUSE_WDT_RUN   = 3'h2,
    CAUSE_WDT_SLP   = 3'h3,
    CAUSE_PIN_WAKE  = 3'h4
  } cause_t;

  // core states, gray along reset -> run -> hold
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RUN   = 2'b01,
    ST_HOLD  = 2'b11
  } state_t;

  // irq bits
  localparam int IRQ_RESET  = 0;
  localparam int IRQ_OTHER  = 1;
  localparam int IRQ_WRITE  = 2;

endpackage : core_pkg

// ### verilog/core_reset_move.sv
`timescale 1ns/1ns
module core_reset_move (
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_I,
  // reset causes, one-cycle pulses, then sleep and memory-size levels
  input  wire logic        POR_I,
  input  wire logic        MASTER_CLEAR_PIN_I,
  input  wire logic        WDT_I,
  input  wire logic        PIN_WAKE_I,
  input  wire logic        SLEEP_I,
  input  wire logic        BIG_MEM_I,
  // instruction stream
  input  wire logic [11:0] INSTR_I,
  input  wire logic        INSTR_VALID_I,
  output logic      [11:0] PASS_INSTR_O,
  output logic             PASS_VALID_O,
  // register port
  input  wire logic [4:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  // outputs
  output logic      [7:0]  DIR_O,
  output logic      [7:0]  PORT_O,
  output logic             IRQ_O
);

  logic [7:0] regs [0:6];
  logic [7:0] working;
  logic [7:0] option;
  logic [7:0] dir;
  logic [2:0] irq_stat;
  logic [2:0] irq_en;
  logic       any_reset;
  logic       is_move;
  logic       is_load;
  logic       is_store;
  logic       is_idle;
  logic [4:0] f_addr;
  logic [7:0] f_val;
  logic [7:0] next_status;
  logic [2:0] irq_set;
  logic       exec;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic match(input logic [11:0] w,
                                 input logic [11:0] m,
                                 input logic [11:0] p);
    match = (w & m) == p;
  endfunction : match

  function automatic logic [7:0] rd_reg(input logic [4:0] a,
                                        input logic [7:0] r0,
                                        input logic [7:0] r1,
                                        input logic [7:0] r2,
                                        input logic [7:0] r3,
                                        input logic [7:0] r4,
                                        input logic [7:0] r5,
                                        input logic [7:0] r6);
    case (a)
      core_pkg::ADDR_INDIRECT: rd_reg = r0;
      core_pkg::ADDR_TIMER:    rd_reg = r1;
      core_pkg::ADDR_PCL:      rd_reg = r2;
      core_pkg::ADDR_STATUS:   rd_reg = r3;
      core_pkg::ADDR_POINTER:  rd_reg = r4;
      core_pkg::ADDR_TRIM:     rd_reg = r5;
      core_pkg::ADDR_PORT:     rd_reg = r6;
      default:                 rd_reg = core_pkg::ZERO_BYTE;
    endcase
  endfunction : rd_reg

  assign any_reset = POR_I | MASTER_CLEAR_PIN_I | WDT_I | PIN_WAKE_I;
  assign exec      = INSTR_VALID_I & ~any_reset;
  assign is_move   = exec & match(INSTR_I, core_pkg::MOVE_REG_MASK,
                                  core_pkg::MOVE_REG_PAT);
  assign is_load   = exec & match(INSTR_I, core_pkg::LOAD_LIT_MASK,
                                  core_pkg::LOAD_LIT_PAT);
  assign is_store  = exec & match(INSTR_I, core_pkg::STORE_W_MASK,
                                  core_pkg::STORE_W_PAT);
  assign is_idle   = exec & (INSTR_I == core_pkg::IDLE_PAT);
  assign f_addr    = INSTR_I[4:0];
  assign f_val     = rd_reg(f_addr, regs[0], regs[1], regs[2], regs[3],
                            regs[4], regs[5], regs[6]);

  // ----------------------------------------------------------------
  // status per reset cause
  // ----------------------------------------------------------------
  always_comb begin
    next_status = regs[3];
    if (PIN_WAKE_I) begin
      next_status = {1'b1, 2'b00, 1'b1, 1'b0, regs[3][2:0]};
    end else if (WDT_I) begin
      next_status = {4'h0, SLEEP_I ? 1'b0 : regs[3][3],
                     regs[3][2:0]};
    end else if (MASTER_CLEAR_PIN_I && SLEEP_I) begin
      next_status = {3'b000, 1'b1, 1'b0, regs[3][2:0]};
    end else if (MASTER_CLEAR_PIN_I) begin
      next_status = {3'b000, regs[3][4:0]};
    end else if (is_move) begin
      next_status[core_pkg::ST_Z] = (f_val == core_pkg::ZERO_BYTE);
    end else if (WR_I && ADDR_I == core_pkg::ADDR_STATUS) begin
      next_status = {regs[3][7], WDATA_I[6:5], regs[3][4:3], WDATA_I[2:0]};
    end
  end

  // ----------------------------------------------------------------
  // special registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      for (int i = 0; i < 7; i++) begin
        regs[i] <= core_pkg::ZERO_BYTE;
      end
      regs[2] <= core_pkg::PCL_RESET;
      regs[3] <= core_pkg::STATUS_POR;
      regs[4] <= core_pkg::POINTER_POR;
    end else if (POR_I) begin
      regs[2] <= core_pkg::PCL_RESET;
      regs[3] <= core_pkg::STATUS_POR;
      regs[4] <= BIG_MEM_I ? core_pkg::POINTER_POR_BIG
                           : core_pkg::POINTER_POR;
    end else if (any_reset) begin
      regs[2] <= core_pkg::PCL_RESET;
      regs[3] <= next_status;
      regs[4] <= BIG_MEM_I ? (regs[4] | core_pkg::POINTER_HI_BIG)
                           : (regs[4] | core_pkg::POINTER_HI_MASK);
    end else begin
      regs[3] <= next_status;
      if (is_store && f_addr < 5'd7 && f_addr != core_pkg::ADDR_STATUS) begin
        regs[f_addr[2:0]] <= working;
      end else if (is_move && INSTR_I[5] &&
                   f_addr < 5'd7 && f_addr != core_pkg::ADDR_STATUS) begin
        regs[f_addr[2:0]] <= f_val;
      end else if (WR_I && ADDR_I < 5'd7 &&
                   ADDR_I != core_pkg::ADDR_STATUS) begin
        regs[ADDR_I[2:0]] <= WDATA_I;
      end
    end
  end

  // ----------------------------------------------------------------
  // working, option, direction
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      working <= core_pkg::ZERO_BYTE;
    end else if (is_load) begin
      working <= INSTR_I[7:0];
    end else if (is_move && !INSTR_I[5]) begin
      working <= f_val;
    end else if (WR_I && ADDR_I == core_pkg::ADDR_WORKING) begin
      working <= WDATA_I;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      option <= core_pkg::OPTION_TOP;
      dir    <= core_pkg::DIR_RESET;
    end else if (any_reset) begin
      option <= POR_I ? core_pkg::OPTION_TOP
                      : (option | core_pkg::OPTION_TOP);
      dir    <= core_pkg::DIR_RESET;
    end else if (WR_I && ADDR_I == core_pkg::ADDR_OPTION) begin
      option <= WDATA_I;
    end else if (WR_I && ADDR_I == core_pkg::ADDR_DIR) begin
      dir <= WDATA_I;
    end
  end

  // ----------------------------------------------------------------
  // pass-through of other words
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PASS_INSTR_O <= 12'h000;
      PASS_VALID_O <= 1'b0;
    end else begin
      PASS_INSTR_O <= INSTR_I;
      PASS_VALID_O <= exec & ~(is_move | is_load | is_store | is_idle);
    end
  end

  // ----------------------------------------------------------------
  // interrupts: set wins over clear
  // ----------------------------------------------------------------
  assign irq_set = {is_store | (is_move & INSTR_I[5]),
                    1'b0,
                    any_reset};

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_stat <= 3'h0;
      irq_en   <= 3'h0;
      IRQ_O    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((WR_I && ADDR_I == core_pkg::ADDR_IRQ_CLR)
                   ? WDATA_I[2:0] : 3'h0)) | irq_set;
      if (WR_I && ADDR_I == core_pkg::ADDR_IRQ_EN) begin
        irq_en <= WDATA_I[2:0];
      end
      IRQ_O <= |(irq_stat & irq_en);
    end
  end

  // ----------------------------------------------------------------
  // read port and pins
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      RDATA_O <= core_pkg::ZERO_BYTE;
      DIR_O   <= core_pkg::DIR_RESET;
      PORT_O  <= core_pkg::ZERO_BYTE;
    end else begin
      DIR_O  <= dir;
      PORT_O <= regs[6];
      if (!RD_I) begin
        RDATA_O <= core_pkg::ZERO_BYTE;
      end else begin
        case (ADDR_I)
          core_pkg::ADDR_IRQ_STAT: RDATA_O <= {5'h00, irq_stat};
          core_pkg::ADDR_IRQ_EN:   RDATA_O <= {5'h00, irq_en};
          core_pkg::ADDR_WORKING:  RDATA_O <= working;
          core_pkg::ADDR_INSTR:    RDATA_O <= {4'h0, PASS_INSTR_O[11:8]};
          default: RDATA_O <= rd_reg(ADDR_I, regs[0], regs[1], regs[2],
                                     regs[3], regs[4], regs[5], regs[6]);
        endcase
      end
    end
  end

endmodule : core_reset_move
